// *** hw/zhe_top.sv ***
// per-zone hold and judgment evaluator for qualified load samples
`timescale 1ns/1ns
`include "zhe_regs.svh"
module zhe_top (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  // sample stream
  input  wire logic                     sample_valid_i,
  input  wire logic signed [`ZHE_W-1:0] load_i,
  input  wire logic        [`ZHE_W-1:0] time_i,
  input  wire logic        [`ZHE_W-1:0] disp_i,
  // zone and measurement
  input  wire logic                     meas_start_i,
  input  wire logic                     x_is_disp_i,
  input  wire logic        [`ZHE_W-1:0] zone_x_lo_i,
  input  wire logic        [`ZHE_W-1:0] zone_x_hi_i,
  input  zhe_pkg::zhe_method_t          method_i,
  input  wire logic signed [`ZHE_W-1:0] high_limit_i,
  input  wire logic signed [`ZHE_W-1:0] low_limit_i,
  // maximum/minimum settings
  input  wire logic        [`ZHE_W-1:0] swing_threshold_i,
  input  wire logic        [7:0]        scale_i,
  input  wire logic        [7:0]        det_count_i,
  input  wire logic                     hold_max_sel_i,
  // inflection settings
  input  wire logic signed [`ZHE_W-1:0] arm_level_i,
  input  wire logic        [`ZHE_W-1:0] span_a_i,
  input  wire logic        [`ZHE_W-1:0] span_b_i,
  input  wire logic                     span_a_disp_i,
  input  wire logic                     span_b_disp_i,
  input  wire logic        [`ZHE_W-1:0] offset_i,
  // results
  output logic signed [`ZHE_W-1:0]      held_value_o,
  output logic        [`ZHE_W-1:0]      held_point_o,
  output logic                          hold_valid_o,
  output logic                          upper_violation_flag_o,
  output logic                          under_limit_flag_o,
  output logic                          zone_pass_o,
  output logic        [7:0]             swing_count_o,
  output logic                          armed_o
);
  // qualification
  wire logic [`ZHE_W-1:0] x_pos   = x_is_disp_i ? disp_i : time_i;
  wire logic              in_zone = (x_pos >= zone_x_lo_i) && (x_pos <= zone_x_hi_i);
  wire logic              smp     = sample_valid_i && !meas_start_i;
  wire logic              zs      = smp && in_zone;
  wire logic              m_pp    = method_i == zhe_pkg::ZHE_M_PP;
  wire logic              m_avg   = method_i == zhe_pkg::ZHE_M_AVG;
  wire logic              m_mm    = method_i == zhe_pkg::ZHE_M_MAXMIN;
  wire logic              m_infl  = method_i == zhe_pkg::ZHE_M_INFL;

  // running average
  logic signed [31:0]         sum;
  logic        [`ZHE_W-1:0]   n_smp;
  wire logic signed [31:0]    next_sum  = sum + {{16{load_i[15]}}, load_i};
  wire logic        [`ZHE_W-1:0] next_n = n_smp + 16'h0001;
  wire logic signed [31:0]    avg_full  = next_sum / $signed({16'h0000, next_n});
  wire logic signed [`ZHE_W-1:0] avg_q  = avg_full[15:0];

  // peak to peak relative to the zone entry
  logic                         pp_on;
  logic signed [`ZHE_WIDE-1:0]  pp_base, pp_max, pp_min;
  wire logic signed [`ZHE_WIDE-1:0] pp_rel  = zhe_pkg::zhe_wide(load_i) - pp_base;
  wire logic signed [`ZHE_WIDE-1:0] pp_hi   = (pp_rel > pp_max) ? pp_rel : pp_max;
  wire logic signed [`ZHE_WIDE-1:0] pp_lo   = (pp_rel < pp_min) ? pp_rel : pp_min;
  wire logic signed [`ZHE_WIDE-1:0] pp_span = pp_hi - pp_lo;

  // maximum/minimum swing detection
  zhe_pkg::zhe_mm_state_t      mm_state;
  logic signed [`ZHE_W-1:0]    ext_val, a_val, b_val;
  logic        [`ZHE_W-1:0]    ext_pt, a_pt, b_pt;
  wire logic signed [`ZHE_WIDE-1:0] margin = {2'b00, {8'h00, swing_threshold_i} * {16'h0000, scale_i}};
  wire logic signed [`ZHE_WIDE-1:0] drop   = zhe_pkg::zhe_wide(ext_val) - zhe_pkg::zhe_wide(load_i);
  wire logic signed [`ZHE_WIDE-1:0] rise   = zhe_pkg::zhe_wide(load_i) - zhe_pkg::zhe_wide(ext_val);
  wire logic mm_run   = zs && m_mm;
  wire logic swing_hi = mm_run && (mm_state == zhe_pkg::ZHE_MM_MAX) && (drop > margin);
  wire logic swing_lo = mm_run && (mm_state == zhe_pkg::ZHE_MM_MIN) && (rise > margin);
  wire logic swing    = swing_hi || swing_lo;
  wire logic [7:0] next_cnt = swing_count_o + 8'h01;
  wire logic count_hit = swing && (next_cnt == det_count_i) && !hold_valid_o;
  wire logic signed [`ZHE_W-1:0] next_a_val = swing_hi ? ext_val : a_val;
  wire logic        [`ZHE_W-1:0] next_a_pt  = swing_hi ? ext_pt  : a_pt;
  wire logic signed [`ZHE_W-1:0] next_b_val = swing_lo ? ext_val : b_val;
  wire logic        [`ZHE_W-1:0] next_b_pt  = swing_lo ? ext_pt  : b_pt;

  // inflection
  logic                     infl_hit;
  logic signed [`ZHE_W-1:0] infl_val;
  logic        [`ZHE_W-1:0] infl_pt;

  zhe_infl u_infl (
    .core_clk_i        (core_clk_i),
    .rst_i             (rst_i),
    .clear_i           (meas_start_i),
    .sample_i          (smp),
    .eval_i            (in_zone && m_infl),
    .load_i            (load_i),
    .time_i            (time_i),
    .disp_i            (disp_i),
    .x_i               (x_pos),
    .arm_level_i       (arm_level_i),
    .span_a_i          (span_a_i),
    .span_b_i          (span_b_i),
    .span_a_disp_i     (span_a_disp_i),
    .span_b_disp_i     (span_b_disp_i),
    .swing_threshold_i (swing_threshold_i),
    .offset_i          (offset_i),
    .hit_o             (infl_hit),
    .value_o           (infl_val),
    .point_o           (infl_pt),
    .armed_o           (armed_o)
  );

  // hold selection per method
  wire logic take_avg  = zs && m_avg;
  wire logic take_pp   = zs && m_pp;
  wire logic take_mm   = count_hit;
  wire logic take_infl = infl_hit && m_infl && !hold_valid_o && !meas_start_i;
  wire logic signed [`ZHE_W-1:0] mm_val = hold_max_sel_i ? next_a_val : next_b_val;
  wire logic        [`ZHE_W-1:0] mm_pt  = hold_max_sel_i ? next_a_pt  : next_b_pt;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sum   <= `ZHE_SUM_RST;
      n_smp <= `ZHE_NCNT_RST;
      pp_on <= 1'b0;
      {pp_base, pp_max, pp_min} <= '0;
    end else if (meas_start_i) begin
      sum   <= `ZHE_SUM_RST;
      n_smp <= `ZHE_NCNT_RST;
      pp_on <= 1'b0;
    end else begin
      if (take_avg) begin
        sum   <= next_sum;
        n_smp <= next_n;
      end
      if (take_pp && !pp_on) begin
        pp_on   <= 1'b1;
        pp_base <= zhe_pkg::zhe_wide(load_i);
        pp_max  <= '0;
        pp_min  <= '0;
      end else if (take_pp) begin
        pp_max <= pp_hi;
        pp_min <= pp_lo;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mm_state      <= zhe_pkg::ZHE_MM_IDLE;
      swing_count_o <= `ZHE_CNT_RST;
      {ext_val, ext_pt, a_val, a_pt, b_val, b_pt} <= '0;
    end else if (meas_start_i) begin
      mm_state      <= zhe_pkg::ZHE_MM_IDLE;
      swing_count_o <= `ZHE_CNT_RST;
    end else if (mm_run) begin
      {a_val, a_pt, b_val, b_pt} <= {next_a_val, next_a_pt, next_b_val, next_b_pt};
      if (swing) begin
        swing_count_o <= next_cnt;
      end
      case (mm_state)
        zhe_pkg::ZHE_MM_IDLE: begin
          {ext_val, ext_pt} <= {load_i, x_pos};
          {a_val, a_pt, b_val, b_pt} <= {load_i, x_pos, load_i, x_pos};
          mm_state <= zhe_pkg::ZHE_MM_MAX;
        end
        zhe_pkg::ZHE_MM_MAX: begin
          if (swing_hi || load_i > ext_val) begin
            {ext_val, ext_pt} <= {load_i, x_pos};
          end
          if (swing_hi) begin
            mm_state <= zhe_pkg::ZHE_MM_MIN;
          end
        end
        zhe_pkg::ZHE_MM_MIN: begin
          if (swing_lo || load_i < ext_val) begin
            {ext_val, ext_pt} <= {load_i, x_pos};
          end
          if (swing_lo) begin
            mm_state <= zhe_pkg::ZHE_MM_MAX;
          end
        end
        default: mm_state <= zhe_pkg::ZHE_MM_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      held_value_o <= `ZHE_HELD_RST;
      held_point_o <= `ZHE_HELD_RST;
      hold_valid_o <= 1'b0;
    end else if (meas_start_i) begin
      held_value_o <= `ZHE_HELD_RST;
      held_point_o <= `ZHE_HELD_RST;
      hold_valid_o <= 1'b0;
    end else if (take_avg || take_pp || take_mm || take_infl) begin
      hold_valid_o <= 1'b1;
      held_point_o <= take_mm ? mm_pt : (take_infl ? infl_pt : x_pos);
      if (take_avg) begin
        held_value_o <= avg_q;
      end else if (take_pp) begin
        held_value_o <= pp_on ? pp_span[15:0] : `ZHE_HELD_RST;
      end else if (take_mm) begin
        held_value_o <= mm_val;
      end else begin
        held_value_o <= infl_val;
      end
    end
  end

  // judgment, one cycle behind the held value
  wire logic over  = hold_valid_o && (high_limit_i < held_value_o);
  wire logic under = hold_valid_o && (held_value_o < low_limit_i);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      upper_violation_flag_o <= 1'b0;
      under_limit_flag_o     <= 1'b0;
      zone_pass_o            <= 1'b0;
    end else begin
      upper_violation_flag_o <= over && !meas_start_i;
      under_limit_flag_o     <= under && !meas_start_i;
      zone_pass_o <= hold_valid_o && !over && !under && !meas_start_i;
    end
  end

  property p_upper;
    @(posedge core_clk_i) disable iff (rst_i)
      hold_valid_o && (held_value_o > high_limit_i) && !meas_start_i |=> upper_violation_flag_o && !zone_pass_o;
  endproperty
  a_upper: assert property (p_upper) else $error("upper flag missing");

  property p_lower;
    @(posedge core_clk_i) disable iff (rst_i)
      hold_valid_o && (held_value_o < low_limit_i) && !meas_start_i |=> under_limit_flag_o && !zone_pass_o;
  endproperty
  a_lower: assert property (p_lower) else $error("lower flag missing");

  property p_edge;
    @(posedge core_clk_i) disable iff (rst_i)
      hold_valid_o && (held_value_o == high_limit_i) && (held_value_o == low_limit_i) && !meas_start_i
      |=> zone_pass_o && !upper_violation_flag_o && !under_limit_flag_o;
  endproperty
  a_edge: assert property (p_edge) else $error("limit compare not strict");

  property p_pass;
    @(posedge core_clk_i) disable iff (rst_i)
      zone_pass_o |-> $past(hold_valid_o) && !upper_violation_flag_o && !under_limit_flag_o;
  endproperty
  a_pass: assert property (p_pass) else $error("pass without in-limit hold");

  property p_clear;
    @(posedge core_clk_i) disable iff (rst_i)
      meas_start_i |=> !hold_valid_o && swing_count_o == 8'h00 && !armed_o ##1 !zone_pass_o;
  endproperty
  a_clear: assert property (p_clear) else $error("state not cleared at start");

  property p_avg;
    @(posedge core_clk_i) disable iff (rst_i)
      take_avg && !meas_start_i |=> hold_valid_o && n_smp == $past(n_smp) + 16'h0001;
  endproperty
  a_avg: assert property (p_avg) else $error("average not accumulated");

  property p_outside;
    @(posedge core_clk_i) disable iff (rst_i)
      !in_zone && !meas_start_i |=> $stable(swing_count_o) && $stable(mm_state);
  endproperty
  a_outside: assert property (p_outside) else $error("extremes tracked outside zone");

  property p_count;
    @(posedge core_clk_i) disable iff (rst_i)
      $rose(hold_valid_o) && m_mm |-> swing_count_o == det_count_i;
  endproperty
  a_count: assert property (p_count) else $error("hold before detection count");

  property p_select;
    @(posedge core_clk_i) disable iff (rst_i)
      take_mm && hold_max_sel_i |=> held_value_o == $past(next_a_val) && held_point_o == $past(next_a_pt);
  endproperty
  a_select: assert property (p_select) else $error("wrong extreme held");

  c_mm_hold:   cover property (@(posedge core_clk_i) disable iff (rst_i) take_mm ##2 zone_pass_o);
  c_infl_hold: cover property (@(posedge core_clk_i) disable iff (rst_i) take_infl ##2 upper_violation_flag_o);
  c_avg_pass:  cover property (@(posedge core_clk_i) disable iff (rst_i) take_avg ##1 !in_zone ##1 zone_pass_o);
endmodule

// *** hw/zhe_regs.svh ***
// widths and reset values of the zone hold evaluator
`ifndef ZHE_REGS_SVH
`define ZHE_REGS_SVH
`define ZHE_W        16
`define ZHE_WIDE     26
`define ZHE_HELD_RST 16'h0000
`define ZHE_CNT_RST  8'h00
`define ZHE_SUM_RST  32'h0000_0000
`define ZHE_NCNT_RST 16'h0000
`endif

// *** hw/zhe_pkg.sv ***
// types and shared arithmetic of the zone hold evaluator
package zhe_pkg;
  typedef enum logic [3:0] {
    ZHE_M_PP     = 4'b0001,
    ZHE_M_AVG    = 4'b0010,
    ZHE_M_MAXMIN = 4'b0100,
    ZHE_M_INFL   = 4'b1000
  } zhe_method_t;

  typedef enum logic [2:0] {
    ZHE_MM_IDLE = 3'b001,
    ZHE_MM_MAX  = 3'b010,
    ZHE_MM_MIN  = 3'b100
  } zhe_mm_state_t;

  typedef enum logic [2:0] {
    ZHE_PH_IDLE = 3'b001,
    ZHE_PH_A    = 3'b010,
    ZHE_PH_B    = 3'b100
  } zhe_phase_t;

  // sign-extend a load to the comparison width
  function automatic logic signed [25:0] zhe_wide(input logic signed [15:0] v);
    zhe_wide = {{10{v[15]}}, v};
  endfunction
endpackage

// *** hw/zhe_infl.sv ***
// slope-change (inflection point) detector for one zone
`timescale 1ns/1ns
`include "zhe_regs.svh"
module zhe_infl (
  // clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  // sample qualification
  input  wire logic                     clear_i,
  input  wire logic                     sample_i,
  input  wire logic                     eval_i,
  input  wire logic signed [`ZHE_W-1:0] load_i,
  input  wire logic        [`ZHE_W-1:0] time_i,
  input  wire logic        [`ZHE_W-1:0] disp_i,
  input  wire logic        [`ZHE_W-1:0] x_i,
  // settings
  input  wire logic signed [`ZHE_W-1:0] arm_level_i,
  input  wire logic        [`ZHE_W-1:0] span_a_i,
  input  wire logic        [`ZHE_W-1:0] span_b_i,
  input  wire logic                     span_a_disp_i,
  input  wire logic                     span_b_disp_i,
  input  wire logic        [`ZHE_W-1:0] swing_threshold_i,
  input  wire logic        [`ZHE_W-1:0] offset_i,
  // result
  output logic                          hit_o,
  output logic signed [`ZHE_W-1:0]      value_o,
  output logic        [`ZHE_W-1:0]      point_o,
  output logic                          armed_o
);
  zhe_pkg::zhe_phase_t phase;
  logic        [`ZHE_W-1:0] p0_t, p0_d, p1_t, p1_d, p1_x;
  logic signed [`ZHE_W-1:0] p0_l, p1_l;

  wire logic        [`ZHE_W-1:0]   dist_a = span_a_disp_i ? disp_i - p0_d : time_i - p0_t;
  wire logic        [`ZHE_W-1:0]   dist_b = span_b_disp_i ? disp_i - p1_d : time_i - p1_t;
  wire logic signed [`ZHE_WIDE-1:0] chg_c = zhe_pkg::zhe_wide(p1_l) - zhe_pkg::zhe_wide(p0_l);
  wire logic signed [`ZHE_WIDE-1:0] chg_e = zhe_pkg::zhe_wide(load_i) - zhe_pkg::zhe_wide(p1_l);
  wire logic signed [`ZHE_WIDE-1:0] chg_d = chg_e - chg_c;
  wire logic signed [`ZHE_WIDE-1:0] thr_w = {10'h000, swing_threshold_i};
  wire logic run    = sample_i && eval_i && armed_o;
  wire logic b_done = (phase == zhe_pkg::ZHE_PH_B) && (dist_b >= span_b_i);
  wire logic found  = run && b_done && (chg_d > thr_w);
  wire logic [`ZHE_W-1:0] shifted = (p1_x > offset_i) ? p1_x - offset_i : `ZHE_HELD_RST;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_o <= 1'b0;
    end else if (clear_i) begin
      armed_o <= 1'b0;
    end else if (sample_i && (load_i > arm_level_i)) begin
      armed_o <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= zhe_pkg::ZHE_PH_IDLE;
      {p0_t, p0_d, p0_l, p1_t, p1_d, p1_l, p1_x} <= '0;
    end else if (clear_i) begin
      phase <= zhe_pkg::ZHE_PH_IDLE;
    end else if (run) begin
      case (phase)
        zhe_pkg::ZHE_PH_IDLE: begin
          {p0_t, p0_d, p0_l} <= {time_i, disp_i, load_i};
          phase              <= zhe_pkg::ZHE_PH_A;
        end
        zhe_pkg::ZHE_PH_A: begin
          if (dist_a >= span_a_i) begin
            {p1_t, p1_d, p1_l, p1_x} <= {time_i, disp_i, load_i, x_i};
            phase                    <= zhe_pkg::ZHE_PH_B;
          end
        end
        zhe_pkg::ZHE_PH_B: begin
          if (dist_b >= span_b_i) begin
            {p0_t, p0_d, p0_l}       <= {p1_t, p1_d, p1_l};
            {p1_t, p1_d, p1_l, p1_x} <= {time_i, disp_i, load_i, x_i};
          end
        end
        default: phase <= zhe_pkg::ZHE_PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hit_o   <= 1'b0;
      value_o <= `ZHE_HELD_RST;
      point_o <= `ZHE_HELD_RST;
    end else begin
      hit_o <= found && !clear_i;
      if (found) begin
        value_o <= p1_l;
        point_o <= shifted;
      end
    end
  end

  property p_infl_armed;
    @(posedge core_clk_i) disable iff (rst_i) hit_o |-> $past(armed_o);
  endproperty
  a_infl_armed: assert property (p_infl_armed) else $error("inflection hit before arming");

  property p_infl_zone;
    @(posedge core_clk_i) disable iff (rst_i) hit_o |-> $past(eval_i) && $past(sample_i);
  endproperty
  a_infl_zone: assert property (p_infl_zone) else $error("inflection hit outside zone");

  property p_infl_offset;
    @(posedge core_clk_i) disable iff (rst_i)
      found && (p1_x > offset_i) |=> point_o == $past(p1_x) - $past(offset_i);
  endproperty
  a_infl_offset: assert property (p_infl_offset) else $error("inflection point not shifted");
endmodule

// *** verification/zhe_load_source.sv ***
// sample source standing in for the measurement front end
`timescale 1ns/1ns
module zhe_load_source (
  // clock
  input  wire logic          core_clk_i,
  // sample stream
  output logic               sample_valid_o,
  output logic signed [15:0] load_o,
  output logic        [15:0] time_o,
  output logic        [15:0] disp_o
);
  initial begin
    sample_valid_o = 1'b0;
    load_o = 16'h0000;
    time_o = 16'h0000;
    disp_o = 16'h0000;
  end

  // one sample per call; idle data is scrambled so stale values cannot pass
  task automatic send(input logic signed [15:0] load, input logic [15:0] t, input logic [15:0] d);
    @(negedge core_clk_i);
    sample_valid_o = 1'b1;
    load_o = load;
    time_o = t;
    disp_o = d;
    @(negedge core_clk_i);
    sample_valid_o = 1'b0;
    load_o = ~load;
    time_o = ~t;
    disp_o = ~d;
  endtask
endmodule

// *** verification/zhe_top_tb_top.sv ***
// self-checking bench for the zone hold evaluator
`timescale 1ns/1ns
module zhe_top_tb_top;
  typedef struct packed {
    logic [3:0]  m;
    logic [15:0] high, low, l0, l1, l2, val;
    logic        valid, up, under, pass;
  } zhe_row_t;

  logic                 core_clk_i, rst_i, meas_start_i, x_is_disp_i, hold_max_sel_i, sample_valid_i, span_disp_i;
  logic signed [15:0]   load_i, high_limit_i, low_limit_i, arm_level_i, held_value_o;
  logic [15:0]          time_i, disp_i, zone_x_lo_i, zone_x_hi_i, swing_threshold_i, span_a_i;
  logic [15:0]          offset_i, held_point_o, tcur;
  logic [7:0]           scale_i, det_count_i, swing_count_o;
  logic                 hold_valid_o, upper_violation_flag_o, under_limit_flag_o, zone_pass_o, armed_o;
  zhe_pkg::zhe_method_t method_i;
  int                   err_count, samples_checked;
  zhe_row_t             rows [7];
  logic [15:0]          iload [8];

  zhe_load_source i_src (.core_clk_i, .sample_valid_o(sample_valid_i), .load_o(load_i), .time_o(time_i),
                         .disp_o(disp_i));

  zhe_top i_dut (.core_clk_i, .rst_i, .sample_valid_i, .load_i, .time_i, .disp_i, .meas_start_i,
                 .x_is_disp_i, .zone_x_lo_i, .zone_x_hi_i, .method_i, .high_limit_i, .low_limit_i,
                 .swing_threshold_i, .scale_i, .det_count_i, .hold_max_sel_i, .arm_level_i, .span_a_i,
                 .span_b_i(span_a_i), .span_a_disp_i(span_disp_i), .span_b_disp_i(span_disp_i), .offset_i,
                 .held_value_o, .held_point_o, .hold_valid_o, .upper_violation_flag_o, .under_limit_flag_o,
                 .zone_pass_o, .swing_count_o, .armed_o);

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic start_meas;
    @(negedge core_clk_i);
    meas_start_i = 1'b1;
    @(negedge core_clk_i);
    meas_start_i = 1'b0;
    tcur = 16'h0000;
  endtask

  task automatic smp(input logic [15:0] load, input logic [15:0] d);
    i_src.send(load, tcur, d);
    tcur = tcur + 16'h0001;
  endtask

  task automatic wait_hold;
    int n;
    n = 0;
    while (hold_valid_o !== 1'b1 && n < 12) begin
      @(negedge core_clk_i);
      n++;
    end
    if (hold_valid_o !== 1'b1) begin
      err_count++;
      $display("Error %0t no hold within bound", $time);
      complete_run();
    end
  endtask

  task automatic judge(input logic v, input logic up, input logic under, input logic pass);
    chk1(hold_valid_o, v, "hold valid");
    chk1(upper_violation_flag_o, up, "upper flag");
    chk1(under_limit_flag_o, under, "under flag");
    chk1(zone_pass_o, pass, "zone pass");
  endtask

  initial begin
    rst_i = 1'b1;
    meas_start_i = 1'b0;
    x_is_disp_i = 1'b1;
    hold_max_sel_i = 1'b1;
    span_disp_i = 1'b0;
    method_i = zhe_pkg::ZHE_M_AVG;
    high_limit_i = 16'h0000;
    low_limit_i = 16'h0000;
    arm_level_i = 16'h0005;
    zone_x_lo_i = 16'h000A;
    zone_x_hi_i = 16'h0014;
    swing_threshold_i = 16'h0005;
    scale_i = 8'h01;
    det_count_i = 8'h01;
    span_a_i = 16'h0002;
    offset_i = 16'h0001;
    tcur = 16'h0000;
    err_count = 0;
    samples_checked = 0;
    rows[0] = '{4'h2, 16'h0019, 16'h000F, 16'h000A, 16'h0014, 16'h001E, 16'h0014, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[1] = '{4'h2, 16'h0013, 16'h0000, 16'h000A, 16'h0014, 16'h001E, 16'h0014, 1'b1, 1'b1, 1'b0, 1'b0};
    rows[2] = '{4'h2, 16'h0028, 16'h0015, 16'h000A, 16'h0014, 16'h001E, 16'h0014, 1'b1, 1'b0, 1'b1, 1'b0};
    rows[3] = '{4'h2, 16'h0014, 16'h0014, 16'h000A, 16'h0014, 16'h001E, 16'h0014, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[4] = '{4'h2, 16'h0000, 16'hFFEC, 16'hFFF6, 16'hFFEC, 16'hFFE1, 16'hFFEC, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[5] = '{4'h1, 16'h000A, 16'h000A, 16'h000A, 16'h000F, 16'h0005, 16'h000A, 1'b1, 1'b0, 1'b0, 1'b1};
    rows[6] = '{4'h0, 16'h0014, 16'h0000, 16'h000A, 16'h0014, 16'h001E, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b0};
    iload = '{16'h000A, 16'h000C, 16'h000C, 16'h000C, 16'h000C, 16'h001E, 16'h001E, 16'h001E};
    cyc(20);
    rst_i = 1'b0;
    judge(1'b0, 1'b0, 1'b0, 1'b0);
    foreach (rows[i]) begin
      method_i = zhe_pkg::zhe_method_t'(rows[i].m);
      high_limit_i = rows[i].high;
      low_limit_i = rows[i].low;
      start_meas();
      chk1(hold_valid_o, 1'b0, "cleared at start");
      smp(16'h7000, 16'h0009);
      smp(rows[i].l0, 16'h000A);
      smp(rows[i].l1, 16'h000F);
      smp(rows[i].l2, 16'h0014);
      smp(16'h7000, 16'h0015);
      cyc(4);
      chk16(held_value_o, rows[i].val, "held value");
      judge(rows[i].valid, rows[i].up, rows[i].under, rows[i].pass);
    end
    $display("average and peak-to-peak rows done");
    // maximum hold after one swing; an out-of-zone spike in between must not count
    method_i = zhe_pkg::ZHE_M_MAXMIN;
    high_limit_i = 16'h0032;
    low_limit_i = 16'h000A;
    start_meas();
    smp(16'h0000, 16'h000A);
    smp(16'h0014, 16'h000B);
    smp(16'h0100, 16'h001E);
    smp(16'h000E, 16'h000C);
    wait_hold();
    cyc(2);
    chk16(held_value_o, 16'h0014, "max value");
    chk16(held_point_o, 16'h000B, "max point");
    chk16({8'h00, swing_count_o}, 16'h0001, "swing count");
    judge(1'b1, 1'b0, 1'b0, 1'b1);
    smp(16'h0030, 16'h000D);
    smp(16'h0000, 16'h000E);
    cyc(3);
    chk16(held_value_o, 16'h0014, "max stays");
    // minimum hold on the second swing, margin is threshold times scale
    hold_max_sel_i = 1'b0;
    swing_threshold_i = 16'h0002;
    scale_i = 8'h02;
    det_count_i = 8'h02;
    start_meas();
    smp(16'h0000, 16'h000A);
    smp(16'h0014, 16'h000B);
    smp(16'h0010, 16'h000C);
    cyc(2);
    chk16({8'h00, swing_count_o}, 16'h0000, "drop equal to margin");
    smp(16'h000E, 16'h000D);
    smp(16'h000A, 16'h000E);
    cyc(3);
    chk16({8'h00, swing_count_o}, 16'h0001, "first swing");
    chk1(hold_valid_o, 1'b0, "no hold before count");
    smp(16'h0010, 16'h000F);
    wait_hold();
    cyc(2);
    chk16(held_value_o, 16'h000A, "min value");
    chk16(held_point_o, 16'h000E, "min point");
    chk16({8'h00, swing_count_o}, 16'h0002, "second swing");
    judge(1'b1, 1'b0, 1'b0, 1'b1);
    $display("maximum/minimum tests done");
    // inflection on time axis, equal spans
    x_is_disp_i = 1'b0;
    zone_x_lo_i = 16'h0000;
    zone_x_hi_i = 16'h0064;
    method_i = zhe_pkg::ZHE_M_INFL;
    high_limit_i = 16'h000A;
    low_limit_i = 16'h0000;
    swing_threshold_i = 16'h0005;
    start_meas();
    smp(16'h0000, 16'h0000);
    cyc(2);
    chk1(armed_o, 1'b0, "not armed below level");
    foreach (iload[i]) begin
      smp(iload[i], 16'h0000);
    end
    wait_hold();
    cyc(3);
    chk1(armed_o, 1'b1, "armed");
    chk16(held_value_o, 16'h000C, "junction load");
    chk16(held_point_o, 16'h0003, "shifted point");
    judge(1'b1, 1'b1, 1'b0, 1'b0);
    // same ramp with both spans counted in displacement, two units per sample
    span_disp_i = 1'b1;
    start_meas();
    foreach (iload[i]) begin
      smp(iload[i], 16'(2 * i));
    end
    wait_hold();
    cyc(3);
    chk16(held_value_o, 16'h000C, "displacement span load");
    chk16(held_point_o, 16'h0003, "displacement span point");
    $display("inflection test done");
    @(negedge core_clk_i);
    rst_i = 1'b1;
    cyc(2);
    judge(1'b0, 1'b0, 1'b0, 1'b0);
    chk1(armed_o, 1'b0, "armed cleared");
    rst_i = 1'b0;
    cyc(1);
    $display("reset test done");
    complete_run();
  end
endmodule
